// *** design/fmt_map.svh ***
// register map, field positions, reset values and timing for the fm tuner config block
// assumes a 125 mhz clock and word-aligned axi4-lite byte addresses
`ifndef FMT_MAP_SVH
`define FMT_MAP_SVH
// ==========================================
// register indices and byte addresses
`define FMT_IDX_CFG1 4
`define FMT_IDX_CFG2 5
`define FMT_IDX_STAT 6
`define FMT_ADDR_CFG1 8'h10
`define FMT_ADDR_CFG2 8'h14
`define FMT_ADDR_STAT 8'h18
// ==========================================
// reset values and writable bit masks
`define FMT_CFG1_RESET 16'h0000
`define FMT_CFG2_RESET 16'h0000
`define FMT_CFG1_MASK 16'hdcff
// ==========================================
// field positions, first configuration register
`define FMT_RDS_IEN 15
`define FMT_STC_IEN 14
`define FMT_RDS_EN 12
`define FMT_DEEMPH 11
`define FMT_AGC_OFF 10
`define FMT_BLEND_LSB 6
`define FMT_PIN_MODE_LSB 0
// field positions, second configuration register
`define FMT_SEEK_LSB 8
`define FMT_BAND_LSB 6
`define FMT_SPACE_LSB 4
`define FMT_VOL_LSB 0
// ==========================================
// timing
`define FMT_CLK_KHZ 125000
`define FMT_IRQ_PULSE_MS 5
`define FMT_IRQ_PULSE_CYC (`FMT_IRQ_PULSE_MS * `FMT_CLK_KHZ)
`endif

// *** design/fmt_pkg.sv ***
// types shared by the fm tuner config block
// assumes nothing beyond a systemverilog compiler
package fmt_pkg;
  // general-purpose pin drive modes
  typedef enum logic [1:0] {
    FMT_PIN_HIZ = 2'h0,
    FMT_PIN_SPECIAL = 2'h1,
    FMT_PIN_LOW = 2'h2,
    FMT_PIN_HIGH = 2'h3
  } fmt_pin_mode_type;
  // interrupt pulse state, one-hot
  typedef enum logic [1:0] {
    FMT_PULSE_IDLE = 2'h1,
    FMT_PULSE_LOW = 2'h2
  } fmt_pulse_state_type;
  // decoded receiver settings handed to rf and audio logic
  typedef struct packed {
    logic radio_data_enable;
    logic deemph_50us;
    logic agc_on;
    logic [5:0] blend_low_dbuv;
    logic [5:0] blend_high_dbuv;
    logic [7:0] seek_level_floor;
    logic [10:0] band_low_100khz;
    logic [10:0] band_high_100khz;
    logic [7:0] spacing_khz;
    logic mute;
    logic [6:0] atten_db;
  } fmt_settings_type;
endpackage

// *** design/fmt_config_gpio.sv ***
// configuration registers and general-purpose pin drivers of an fm receiver
// assumes an axi4-lite master, synchronous status inputs and one 125 mhz clock
`timescale 1ns/100ps
`include "fmt_map.svh"
module fmt_config_gpio #(
  parameter int PULSE_CYCLES = `FMT_IRQ_PULSE_CYC,
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] rssi,
  input wire logic tune_done,
  input wire logic tune_active,
  input wire logic radio_data_ready,
  input wire logic volume_range_extend,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  output logic two_channel_flag,
  output logic seek_channel_valid,
  output fmt_pkg::fmt_settings_type settings
);
  localparam logic [19:0] PULSE_LAST = 20'(PULSE_CYCLES - 1);
  // ==========================================
  // address decode, shared by the write and read paths
  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    if (a == ADDR_W'(`FMT_ADDR_CFG1)) begin
      reg_sel = 2'h1;
    end else if (a == ADDR_W'(`FMT_ADDR_CFG2)) begin
      reg_sel = 2'h2;
    end else if (a == ADDR_W'(`FMT_ADDR_STAT)) begin
      reg_sel = 2'h3;
    end else begin
      reg_sel = 2'h0;
    end
  endfunction
  // pin drive per mode: returns {oe, out}; pin 1 has no special function
  function automatic logic [1:0] pin_drive(input logic [1:0] mode, input logic sp_en,
                                           input logic sp_val);
    case (fmt_pkg::fmt_pin_mode_type'(mode))
      fmt_pkg::FMT_PIN_SPECIAL: pin_drive = {sp_en, sp_en & sp_val};
      fmt_pkg::FMT_PIN_LOW: pin_drive = 2'h2;
      fmt_pkg::FMT_PIN_HIGH: pin_drive = 2'h3;
      default: pin_drive = 2'h0;
    endcase
  endfunction
  // ==========================================
  // register and bus state
  logic [15:0] cfg1; // first configuration register
  logic [15:0] cfg2; // second configuration register
  logic [15:0] next_cfg1;
  logic [15:0] next_cfg2;
  logic aw_held; // write address taken, waiting for data
  logic w_held; // write data taken, waiting for address
  logic [ADDR_W-1:0] aw_addr;
  logic [15:0] w_data; // only the low half is ever stored
  logic [1:0] w_strb;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [15:0] next_w_data;
  logic [1:0] next_w_strb;
  logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [15:0] stat_word; // live status for reads
  // ==========================================
  // flag and pulse state
  logic seek_tune_complete; // seek/tune complete flag
  logic rdr_q; // last radio-data ready level, for edge detect
  logic next_stc;
  fmt_pkg::fmt_pulse_state_type pulse_state;
  fmt_pkg::fmt_pulse_state_type next_pulse_state;
  logic [19:0] pulse_cnt;
  logic [19:0] next_pulse_cnt;
  logic pulse_trig;
  logic pulse_low;
  logic [2:0] next_pin_out;
  logic [2:0] next_pin_oe;
  logic next_two_channel;
  logic next_seek_valid;
  fmt_pkg::fmt_settings_type next_settings;
  // ready outputs are combinational: awready and wready off the hold flags, arready off rvalid
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  assign pulse_low = (pulse_state == fmt_pkg::FMT_PULSE_LOW);
  assign stat_word = {9'h000, pin_in, pulse_low, two_channel_flag, radio_data_ready, seek_tune_complete};
  // ==========================================
  // axi write and read paths with register storage
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_cfg1 = cfg1;
    next_cfg2 = cfg2;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    // address and data may arrive in either order
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata[15:0];
      next_w_strb = s_axi_wstrb[1:0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // commit once both halves are held and no response is pending
    if (aw_held && w_held && !s_axi_bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = 2'h0;
      case (reg_sel(aw_addr))
        2'h1: begin
          // reserved bits are forced to zero whatever the host sends
          if (w_strb[0]) next_cfg1[7:0] = w_data[7:0] & 8'(`FMT_CFG1_MASK);
          if (w_strb[1]) next_cfg1[15:8] = w_data[15:8] & 8'(`FMT_CFG1_MASK >> 8);
        end
        2'h2: begin
          if (w_strb[0]) next_cfg2[7:0] = w_data[7:0];
          if (w_strb[1]) next_cfg2[15:8] = w_data[15:8];
        end
        2'h3: next_bresp = 2'h0; // status is read-only, write dropped
        default: next_bresp = 2'h2;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_axi_rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = 2'h0;
      case (reg_sel(s_axi_araddr))
        2'h1: next_rdata = {16'h0000, cfg1};
        2'h2: next_rdata = {16'h0000, cfg2};
        2'h3: next_rdata = {16'h0000, stat_word};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = 2'h2;
        end
      endcase
    end
  end
  // register the bus state; config registers clear on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg1 <= `FMT_CFG1_RESET;
      cfg2 <= `FMT_CFG2_RESET;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 16'h0000;
      w_strb <= 2'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      cfg1 <= next_cfg1;
      cfg2 <= next_cfg2;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end
  // ==========================================
  // flag, interrupt pulse and settings decode
  always_comb begin
    logic [1:0] blend;
    logic [3:0] vol;
    blend = cfg1[`FMT_BLEND_LSB +: 2];
    vol = cfg2[`FMT_VOL_LSB +: 4];
    // set wins over clear: a finish in the clearing cycle is kept
    next_stc = tune_done | (seek_tune_complete & tune_active);
    pulse_trig = (cfg1[`FMT_PIN_MODE_LSB + 2 +: 2] == 2'h1) &&
      ((cfg1[`FMT_RDS_IEN] && radio_data_ready && !rdr_q) ||
       (cfg1[`FMT_STC_IEN] && tune_done && !seek_tune_complete));
    next_pulse_state = pulse_state;
    next_pulse_cnt = pulse_cnt;
    case (pulse_state)
      fmt_pkg::FMT_PULSE_IDLE: begin
        if (pulse_trig) begin
          next_pulse_state = fmt_pkg::FMT_PULSE_LOW;
          next_pulse_cnt = PULSE_LAST;
        end
      end
      fmt_pkg::FMT_PULSE_LOW: begin
        // a new event during the pulse restarts the full width
        if (pulse_trig) begin
          next_pulse_cnt = PULSE_LAST;
        end else if (pulse_cnt == 20'h00000) begin
          next_pulse_state = fmt_pkg::FMT_PULSE_IDLE;
        end else begin
          next_pulse_cnt = pulse_cnt - 20'h00001;
        end
      end
      default: next_pulse_state = fmt_pkg::FMT_PULSE_IDLE;
    endcase
    // blend window low ends: 31, 37, 19, 25 dbuv
    case (blend)
      2'h0: next_settings.blend_low_dbuv = 6'd31;
      2'h1: next_settings.blend_low_dbuv = 6'd37;
      2'h2: next_settings.blend_low_dbuv = 6'd19;
      default: next_settings.blend_low_dbuv = 6'd25;
    endcase
    next_settings.blend_high_dbuv = next_settings.blend_low_dbuv + 6'd18;
    next_two_channel = rssi > {2'h0, next_settings.blend_low_dbuv};
    next_seek_valid = rssi >= cfg2[`FMT_SEEK_LSB +: 8];
    next_settings.radio_data_enable = cfg1[`FMT_RDS_EN];
    next_settings.deemph_50us = cfg1[`FMT_DEEMPH];
    next_settings.agc_on = !cfg1[`FMT_AGC_OFF];
    next_settings.seek_level_floor = cfg2[`FMT_SEEK_LSB +: 8];
    case (cfg2[`FMT_BAND_LSB +: 2])
      2'h0: next_settings.band_low_100khz = 11'd875;
      2'h3: next_settings.band_low_100khz = 11'd640;
      default: next_settings.band_low_100khz = 11'd760;
    endcase
    next_settings.band_high_100khz = (cfg2[`FMT_BAND_LSB +: 2] == 2'h2) ? 11'd900 : 11'd1080;
    // code 11 has no spacing; zero flags it to the tuning logic
    case (cfg2[`FMT_SPACE_LSB +: 2])
      2'h0: next_settings.spacing_khz = 8'd200;
      2'h1: next_settings.spacing_khz = 8'd100;
      2'h2: next_settings.spacing_khz = 8'd50;
      default: next_settings.spacing_khz = 8'd0;
    endcase
    // 2 db per step below full scale, plus 30 db when extended
    next_settings.mute = (vol == 4'h0);
    next_settings.atten_db = 7'({3'h0, 4'hf - vol} << 1) +
      (volume_range_extend ? 7'd30 : 7'd0);
  end
  // per-pin drive: pin 2 idles high around the pulse, pin 3 shows stereo
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pin
      logic [1:0] drv;
      assign drv = pin_drive(cfg1[`FMT_PIN_MODE_LSB + 2*g +: 2], g != 0,
        (g == 1) ? !next_pulse_state[1] : next_two_channel);
      assign next_pin_oe[g] = drv[1];
      assign next_pin_out[g] = drv[0];
    end
  endgenerate
  // register flags, pulse timer, pins and decoded settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seek_tune_complete <= 1'b0;
      rdr_q <= 1'b0;
      pulse_state <= fmt_pkg::FMT_PULSE_IDLE;
      pulse_cnt <= 20'h00000;
      pin_out <= 3'h0;
      pin_oe <= 3'h0;
      two_channel_flag <= 1'b0;
      seek_channel_valid <= 1'b0;
      settings <= '0;
    end else begin
      seek_tune_complete <= next_stc;
      rdr_q <= radio_data_ready;
      pulse_state <= next_pulse_state;
      pulse_cnt <= next_pulse_cnt;
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      two_channel_flag <= next_two_channel;
      seek_channel_valid <= next_seek_valid;
      settings <= next_settings;
    end
  end
  // ==========================================
  // checks
  a_rds_pulse_start: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg1[15] && cfg1[3:2] == 2'h1 && $rose(radio_data_ready) |=> pulse_low ##1 !pin_out[1])
    else $error("radio-data event did not pull pin 2 low");
  a_stc_pulse_start: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg1[14] && cfg1[3:2] == 2'h1 && tune_done && !seek_tune_complete |=> pulse_low ##1 !pin_out[1])
    else $error("seek/tune event did not pull pin 2 low");
  a_pin2_idle_high: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(cfg1[3:2]) == 2'h1 && $past(pulse_state) == fmt_pkg::FMT_PULSE_IDLE &&
    $past(!pulse_trig) |-> pin_oe[1] && pin_out[1])
    else $error("pin 2 not high outside a pulse");
  a_pin_fixed_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg1[1:0] == 2'h2 |=> pin_oe[0] && !pin_out[0])
    else $error("pin 1 low mode not driven low");
  a_pin3_stereo: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg1[5:4] == 2'h1 |=> pin_oe[2] && pin_out[2] == two_channel_flag)
    else $error("pin 3 does not follow stereo");
  a_cfg_reset_zero: assert property (@(posedge aclk)
    !aresetn |=> cfg1 == 16'h0000 && cfg2 == 16'h0000 && pin_oe == 3'h0)
    else $error("config not zero after reset");
  a_pulse_ends: assert property (@(posedge aclk) disable iff (!aresetn)
    pulse_low && pulse_cnt == 20'h00000 && !pulse_trig |=> !pulse_low)
    else $error("pulse did not end at count expiry");
  a_pulse_counts: assert property (@(posedge aclk) disable iff (!aresetn)
    pulse_low && pulse_cnt != 20'h00000 && !pulse_trig |=> pulse_low &&
    pulse_cnt == $past(pulse_cnt) - 20'h00001)
    else $error("pulse counter did not step down");
  a_stc_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    tune_done |=> seek_tune_complete)
    else $error("tune finish did not raise flag");
  a_stereo_rule: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg1[7:6] == 2'h0 && rssi == 8'd32 |=> two_channel_flag)
    else $error("stereo flag missing above blend low end");
  a_volume_mute: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg2[3:0] == 4'hf && !volume_range_extend |=> settings.atten_db == 7'd0 && !settings.mute)
    else $error("full-scale volume code not zero attenuation");
endmodule

// *** bench/fmt_host_model.sv ***
// host-side model: pull-ups on the three pins and a watcher of pin 2 pulses
// assumes pin_out/pin_oe from the config block and its clock
`timescale 1ns/100ps
module fmt_host_model (
  input wire logic aclk,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  output logic [2:0] pin_level,
  output int low_width,
  output int pulse_count
);
  int run; // edges seen with pin 2 low so far
  // ==========================================
  // wire level: released pins float up on the board pull-ups
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : 1'b1;
    end
  end
  // pulse width meter, latched when pin 2 returns high
  always @(posedge aclk) begin
    if (pin_level[1] === 1'b0) begin
      run <= run + 1;
    end else if (run > 0) begin
      low_width <= run;
      pulse_count <= pulse_count + 1;
      run <= 0;
    end
  end
  // host habits: pin 1 mode 01 never chosen reserved bits written 0
  // and spacing 11 never programmed the bench stimulus keeps all three
  initial begin
    run = 0;
    low_width = 0;
    pulse_count = 0;
  end
endmodule

// *** bench/fmt_config_gpio_tb.sv ***
// self-checking bench for the fm tuner config registers and pin drivers
// assumes fmt_host_model beside it and a 125 mhz clock
`timescale 1ns/100ps
`include "fmt_map.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
module fmt_config_gpio_tb;
  localparam int P = 20; // short pulse keeps the run brief
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, tdone, tact, rdr, vext;
  logic two_ch, seek_ok;
  logic [7:0] awaddr, araddr, rssi;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [2:0] pin_out, pin_oe, lvl;
  logic [15:0] c1, c2;
  fmt_pkg::fmt_settings_type st;
  int num_errors, check_count, pcnt, lw, n0, lo;
  int blo[4] = '{31, 37, 19, 25}; // blend window low ends
  int bl[4] = '{875, 760, 760, 640};
  int bh[4] = '{1080, 1080, 900, 1080};
  int sp[4] = '{200, 100, 50, 0};
  logic [1:0] md[3] = '{2'h0, 2'h2, 2'h3};
  // ==========================================
  // design and host model
  fmt_config_gpio #(.PULSE_CYCLES(P)) i_fmt_config_gpio (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rssi(rssi), .tune_done(tdone), .tune_active(tact), .radio_data_ready(rdr),
    .volume_range_extend(vext), .pin_in(lvl), .pin_out(pin_out), .pin_oe(pin_oe),
    .two_channel_flag(two_ch), .seek_channel_valid(seek_ok), .settings(st));
  fmt_host_model i_fmt_host_model (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_level(lvl), .low_width(lw), .pulse_count(pcnt));
  // ==========================================
  // bus tasks: valid held until its own ready edge
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0, v};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // no local limit: only the watchdog ends a wait
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // verdict, shared by the main sequence and the watchdog
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // clock and watchdog
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    tick(20000);
    num_errors++;
    report_and_stop;
  end
  // ==========================================
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, tdone, tact, rdr, vext} = '0;
    {awaddr, araddr, rssi, wdata, wstrb} = '0;
    num_errors = 0;
    check_count = 0;
    void'($urandom(15358));
    tick(20);
    aresetn <= 1'b1;
    tick(1);
    // reset values, and an unmapped write that must leave them alone
    wr(8'h20, 16'h1234, r);
    `CHK(r, 2'h2)
    rd(`FMT_ADDR_CFG1, d, r);
    `CHK(d, 32'h0)
    rd(`FMT_ADDR_CFG2, d, r);
    `CHK(d, 32'h0)
    `CHK(pin_oe, 3'h0)
    $display("test reset done");
    // static pin modes on all three pins at once
    foreach (md[k]) begin
      wr(`FMT_ADDR_CFG1, 16'({md[k], md[k], md[k]}), r);
      tick(2);
      `CHK(pin_oe, (md[k] == 2'h0) ? 3'h0 : 3'h7)
      `CHK(lvl, (md[k] == 2'h2) ? 3'h0 : 3'h7)
    end
    $display("test pin modes done");
    // random settings, rssi at window and floor edges
    for (int i = 0; i < 8; i++) begin
      c1 = (16'($urandom) & 16'hdcc0) | 16'h0010;
      if (i == 2) c1[7:6] = 2'h0; // blend 00 puts rssi 32 just above the window low end
      c2 = 16'($urandom) & 16'h7fff; // floor within 0x00..0x7f
      if (c2[5:4] == 2'h3) c2[5] = 1'b0;
      if (i == 0) c2[3:0] = 4'hf; // full-scale volume seen at least once
      lo = blo[c1[7:6]];
      rssi <= (i < 3) ? 8'(lo + i - 1) : (i == 3) ? c2[15:8] : 8'($urandom_range(90));
      vext <= (i == 0) ? 1'b0 : 1'($urandom);
      wr(`FMT_ADDR_CFG1, c1, r);
      wr(`FMT_ADDR_CFG2, c2, r);
      tick(2);
      `CHK(two_ch, int'(rssi) > lo)
      `CHK(pin_out[2], int'(rssi) > lo)
      `CHK(seek_ok, rssi >= c2[15:8])
      `CHK(st.radio_data_enable, c1[12])
      `CHK(st.deemph_50us, c1[11])
      `CHK(st.agc_on, ~c1[10])
      `CHK(st.blend_low_dbuv, 6'(lo))
      `CHK(st.blend_high_dbuv, 6'(lo + 18))
      `CHK(st.seek_level_floor, c2[15:8])
      `CHK(st.band_low_100khz, 11'(bl[c2[7:6]]))
      `CHK(st.band_high_100khz, 11'(bh[c2[7:6]]))
      `CHK(st.spacing_khz, 8'(sp[c2[5:4]]))
      `CHK(st.mute, c2[3:0] == 4'h0)
      if (c2[3:0] != 4'h0) `CHK(st.atten_db, 7'(2 * (15 - c2[3:0]) + 30 * vext))
      rd(`FMT_ADDR_CFG2, d, r);
      `CHK(d, {16'h0000, c2})
      `CHK(r, 2'h0)
    end
    $display("test settings done");
    // pin 2 interrupt pulses, first from radio data then from tune end
    wr(`FMT_ADDR_CFG1, 16'h8004, r);
    tick(2);
    `CHK(lvl[1], 1'b1)
    `CHK(pin_oe[1], 1'b1)
    n0 = pcnt;
    rdr <= 1'b1;
    tick(P + 6);
    `CHK(pcnt, n0 + 1)
    `CHK(lw, P)
    rdr <= 1'b0;
    wr(`FMT_ADDR_CFG1, 16'h4004, r);
    tact <= 1'b1;
    tdone <= 1'b1;
    tick(1);
    tdone <= 1'b0;
    tick(P + 6);
    `CHK(pcnt, n0 + 2)
    `CHK(lw, P)
    rd(`FMT_ADDR_STAT, d, r);
    `CHK(d[0], 1'b1)
    tact <= 1'b0;
    // enable off: a radio data event must not pulse
    wr(`FMT_ADDR_CFG1, 16'h0004, r);
    rdr <= 1'b1;
    tick(P + 6);
    `CHK(pcnt, n0 + 2)
    `CHK(lvl[1], 1'b1)
    $display("test pulses done");
    report_and_stop;
  end
endmodule
